/* dnwc_top.sv */
// write and read control for the byte-wide data nonvolatile array
// assumes synchronous inputs, one clock, a bus master that never waits
`timescale 1ns/1ps
`default_nettype none
module dnwc_top #(
    parameter int WRITE_CYCLES = dnwc_pkg::WRITE_CYC,
    parameter int HOLD_CYCLES = dnwc_pkg::HOLD_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // external programming port
    input wire logic code_protect_i,
    input wire logic ext_we_i,
    input wire logic ext_re_i,
    input wire logic [7:0] ext_addr_i,
    input wire logic [7:0] ext_wdata_i,
    output logic [7:0] ext_rdata_o,
    output logic ext_ready_o,
    // status
    output logic write_busy_o,
    output logic nvm_done_irq_o
);
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic space;
        logic cfg;
        logic free;
        logic abort;
        logic enable;
        logic commit;
        dnwc_pkg::dnwc_unl_type unl;
        logic [31:0] wcnt;
        logic [31:0] hold;
        logic done;
        logic done_ie;
        logic done_ip;
        logic rd_pend;
        logic ext_pend;
        logic [7:0] rdata;
        logic [7:0] erdata;
        logic ext_ready;
        logic irq;
    } dnwc_state_type;

    dnwc_state_type st_r, st_nxt;
    dnwc_pkg::dnwc_bus_type bus;
    logic [7:0] mem_q;
    logic [7:0] mem_raddr;
    logic mem_re;
    logic [7:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic hold_done;
    logic ext_ok;
    logic wr_last;
    logic core_rd;

    assign bus = '{we: reg_we_i, re: reg_re_i, addr: reg_addr_i, wdata: reg_wdata_i};
    assign hold_done = (st_r.hold == 32'(HOLD_CYCLES));
    assign ext_ok = !code_protect_i && !st_r.commit;
    assign wr_last = st_r.commit && (st_r.wcnt == 32'(WRITE_CYCLES - 1));
    // core read starts on the control write itself, whatever the protect bit
    assign core_rd = bus.we && bus.addr == dnwc_pkg::OFS_CTRL && !st_r.commit
        && bus.wdata[dnwc_pkg::CTRL_READ] && !bus.wdata[dnwc_pkg::CTRL_SPACE];

    function automatic logic [7:0] ctrl_view(input dnwc_state_type s);
        // bit 5 unimplemented, reads zero
        ctrl_view = {s.space, s.cfg, 1'b0, s.free, s.abort, s.enable, s.commit, 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // memory: core read wins port; ext read uses it when the core is quiet
    assign mem_re = core_rd || (ext_re_i && ext_ok);
    assign mem_raddr = core_rd ? st_r.addr : ext_addr_i;
    // array is written on the edge that ends the write, so busy low means stored
    assign mem_we = wr_last || (ext_we_i && ext_ok && hold_done);
    assign mem_waddr = wr_last ? st_r.addr : ext_addr_i;
    assign mem_wdata = wr_last ? st_r.data : ext_wdata_i;

    dnwc_mem #(.AW(8)) dnwc_mem_inst (
        .mclk_i(mclk_i),
        .wen_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .ren_i(mem_re),
        .raddr_i(mem_raddr),
        .rdata_o(mem_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rd_pend = 1'b0;
        st_nxt.ext_pend = 1'b0;
        st_nxt.ext_ready = 1'b0;
        if (!hold_done)
        begin
            st_nxt.hold = st_r.hold + 32'd1;
        end
        // finished read lands in the data register
        if (st_r.rd_pend)
        begin
            st_nxt.data = mem_q;
        end
        if (st_r.ext_pend)
        begin
            st_nxt.erdata = mem_q;
            st_nxt.ext_ready = 1'b1;
        end
        if (ext_re_i && ext_ok && !core_rd)
        begin
            st_nxt.ext_pend = 1'b1;
        end
        // self-timed write
        if (st_r.commit)
        begin
            st_nxt.wcnt = st_r.wcnt + 32'd1;
            if (st_r.wcnt == 32'(WRITE_CYCLES - 1))
            begin
                st_nxt.commit = 1'b0;
                st_nxt.abort = 1'b0;
                st_nxt.done = 1'b1;
            end
        end
        if (bus.we)
        begin
            unique case (bus.addr)
                dnwc_pkg::OFS_ADDR:
                begin
                    if (!st_r.commit) st_nxt.addr = bus.wdata;
                end
                dnwc_pkg::OFS_DATA:
                begin
                    if (!st_r.commit && !st_r.rd_pend) st_nxt.data = bus.wdata;
                end
                dnwc_pkg::OFS_CTRL:
                begin
                    if (!st_r.commit)
                    begin
                        st_nxt.space = bus.wdata[dnwc_pkg::CTRL_SPACE];
                        st_nxt.cfg = bus.wdata[dnwc_pkg::CTRL_CFG];
                        st_nxt.free = bus.wdata[dnwc_pkg::CTRL_FREE];
                        st_nxt.abort = bus.wdata[dnwc_pkg::CTRL_ABORT];
                        st_nxt.enable = bus.wdata[dnwc_pkg::CTRL_ENABLE];
                        // old enable gates commit, so same-write set fails
                        if (bus.wdata[dnwc_pkg::CTRL_COMMIT] && st_r.enable
                            && st_r.unl == dnwc_pkg::UNL_ARMED && hold_done
                            && !st_r.space && !st_r.cfg)
                        begin
                            st_nxt.commit = 1'b1;
                            st_nxt.abort = 1'b1;
                            st_nxt.wcnt = 32'd0;
                        end
                        st_nxt.rd_pend = core_rd;
                    end
                end
                dnwc_pkg::OFS_FLAG2:
                begin
                    // hardware set wins over software clear
                    st_nxt.done = st_nxt.done | bus.wdata[dnwc_pkg::FLAG2_DONE];
                    if (!bus.wdata[dnwc_pkg::FLAG2_DONE] && !wr_last) st_nxt.done = 1'b0;
                end
                dnwc_pkg::OFS_ENABLE2: st_nxt.done_ie = bus.wdata[dnwc_pkg::FLAG2_DONE];
                dnwc_pkg::OFS_PRIO2: st_nxt.done_ip = bus.wdata[dnwc_pkg::FLAG2_DONE];
                default: ;
            endcase
        end
        // unlock sequencer: any other register write breaks the sequence
        if (bus.we)
        begin
            if (bus.addr == dnwc_pkg::OFS_UNLOCK)
            begin
                if (bus.wdata == dnwc_pkg::KEY_FIRST) st_nxt.unl = dnwc_pkg::UNL_KEY1;
                else if (bus.wdata == dnwc_pkg::KEY_SECOND && st_r.unl == dnwc_pkg::UNL_KEY1)
                    st_nxt.unl = dnwc_pkg::UNL_ARMED;
                else st_nxt.unl = dnwc_pkg::UNL_IDLE;
            end
            else
            begin
                st_nxt.unl = dnwc_pkg::UNL_IDLE;
            end
        end
        st_nxt.irq = st_nxt.done && st_nxt.done_ie;
        if (bus.re)
        begin
            unique case (bus.addr)
                dnwc_pkg::OFS_ADDR: st_nxt.rdata = st_r.addr;
                // a read landing this edge is passed through
                dnwc_pkg::OFS_DATA: st_nxt.rdata = st_r.rd_pend ? mem_q : st_r.data;
                dnwc_pkg::OFS_CTRL: st_nxt.rdata = ctrl_view(st_r);
                dnwc_pkg::OFS_FLAG2: st_nxt.rdata = {3'b000, st_r.done, 4'h0};
                dnwc_pkg::OFS_ENABLE2: st_nxt.rdata = {3'b000, st_r.done_ie, 4'h0};
                dnwc_pkg::OFS_PRIO2: st_nxt.rdata = {3'b000, st_r.done_ip, 4'h0};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        else
        begin
            st_nxt.rdata = 8'h00;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= '0;
            // abort survives reset so a cut write stays visible; unknown at power-up
            st_r.abort <= st_r.abort;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign ext_rdata_o = st_r.erdata;
    assign ext_ready_o = st_r.ext_ready;
    assign write_busy_o = st_r.commit;
    assign nvm_done_irq_o = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////
    commit_needs_enable_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(st_r.commit) |-> $past(st_r.enable))
        else $error("commit set without prior enable");
    commit_needs_keys_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(st_r.commit) |-> $past(st_r.unl) == dnwc_pkg::UNL_ARMED)
        else $error("commit set without unlock");
    enable_sticky_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(st_r.enable) |-> $past(bus.we) && $past(bus.addr) == dnwc_pkg::OFS_CTRL)
        else $error("enable cleared by hardware");
    addr_locked_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        st_r.commit && $past(st_r.commit) |-> $stable(st_r.addr))
        else $error("address changed during write");
    done_on_end_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(st_r.commit) |-> st_r.done && !st_r.abort)
        else $error("write end without done");
    hold_blocks_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(st_r.commit) |-> $past(hold_done))
        else $error("write during hold period");
    unlock_reads_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        bus.re && bus.addr == dnwc_pkg::OFS_UNLOCK |=> reg_rdata_o == 8'h00)
        else $error("unlock port read nonzero");
    abort_set_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(st_r.commit) |-> st_r.abort)
        else $error("abort flag not set at commit");
    protect_blocks_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ext_re_i && code_protect_i |-> ##2 !st_r.ext_ready)
        else $error("external read under protection");
endmodule
`default_nettype wire

/* dnwc_pkg.sv */
// package for the data nonvolatile write control block
// assumes a single 100 MHz core clock and a plain register port
package dnwc_pkg;
    // register offsets on the plain port
    localparam logic [2:0] OFS_ADDR = 3'h0;
    localparam logic [2:0] OFS_DATA = 3'h1;
    localparam logic [2:0] OFS_CTRL = 3'h2;
    localparam logic [2:0] OFS_UNLOCK = 3'h3;
    localparam logic [2:0] OFS_FLAG2 = 3'h4;
    localparam logic [2:0] OFS_ENABLE2 = 3'h5;
    localparam logic [2:0] OFS_PRIO2 = 3'h6;
    // control register bit positions, then the done bit of the flag, enable and priority registers
    localparam int CTRL_SPACE = 7;
    localparam int CTRL_CFG = 6;
    localparam int CTRL_FREE = 4;
    localparam int CTRL_ABORT = 3;
    localparam int CTRL_ENABLE = 2;
    localparam int CTRL_COMMIT = 1;
    localparam int CTRL_READ = 0;
    localparam int FLAG2_DONE = 4;
    // unlock keys
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // timing: clock, default self-timed write length and hold length
    localparam int CLK_MHZ = 100;
    localparam int WRITE_US = 4000;
    localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
    localparam int HOLD_US = 65000;
    localparam int HOLD_CYC = HOLD_US * CLK_MHZ;

    typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_ARMED} dnwc_unl_type;

    typedef struct packed {
        logic we;
        logic re;
        logic [2:0] addr;
        logic [7:0] wdata;
    } dnwc_bus_type;
endpackage

/* dnwc_mem.sv */
// 256 x 8 storage for the data array
// assumes one clock; read data come out registered one cycle after ren
`timescale 1ns/1ps
`default_nettype none
module dnwc_mem #(
    parameter int AW = 8
) (
    // clock
    input wire logic mclk_i,
    // write port
    input wire logic wen_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // read port
    input wire logic ren_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_r [0:(1<<AW)-1];

    always_ff @(posedge mclk_i)
    begin
        if (wen_i)
        begin
            mem_r[waddr_i] <= wdata_i;
        end
        if (ren_i)
        begin
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule
`default_nettype wire

/* tb_data_nvm_write_control.sv */
// self-checking bench for the data nonvolatile write control block
// assumes dnwc_top with a short write count and hold count, one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_data_nvm_write_control;
    localparam int WC = 20;
    // hold longer than the first attempted write, so it lands inside it
    localparam int HC = 40;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic code_protect_i = 1'b0;
    logic ext_we_i = 1'b0;
    logic ext_re_i = 1'b0;
    logic [7:0] ext_addr_i = 8'h00;
    logic [7:0] ext_wdata_i = 8'h00;
    logic [7:0] ext_rdata_o;
    logic ext_ready_o;
    logic write_busy_o;
    logic nvm_done_irq_o;
    int n_fail = 0;
    int total_checks = 0;
    logic [7:0] d;
    logic ok;

    dnwc_top #(.WRITE_CYCLES(WC), .HOLD_CYCLES(HC)) dnwc_top_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .code_protect_i(code_protect_i), .ext_we_i(ext_we_i), .ext_re_i(ext_re_i),
        .ext_addr_i(ext_addr_i), .ext_wdata_i(ext_wdata_i), .ext_rdata_o(ext_rdata_o),
        .ext_ready_o(ext_ready_o), .write_busy_o(write_busy_o),
        .nvm_done_irq_o(nvm_done_irq_o)
    );

    always #5 mclk_i = ~mclk_i;

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    // each access leaves one idle edge so no strobe is driven twice per step
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_we_i <= 1'b1;
        @(posedge mclk_i);
        reg_we_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge mclk_i);
        reg_re_i <= 1'b0;
        #1 v = reg_rdata_o;
        @(posedge mclk_i);
    endtask

    task automatic seq(input logic [7:0] k1, input logic [7:0] k2);
        // keys back to back, nothing else on the bus between them
        wr(3'h3, k1);
        wr(3'h3, k2);
        wr(3'h2, 8'h06);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy_o !== 1'b0)
        begin
            if (n++ > 100)
            begin
                n_fail++;
                give_verdict();
            end
            @(posedge mclk_i);
        end
    endtask

    task automatic core_rd(input logic [7:0] a, output logic [7:0] v);
        wr(3'h0, a);
        wr(3'h2, 8'h05);
        rd(3'h1, v);
    endtask

    task automatic ext_rd(input logic [7:0] a, output logic [7:0] v, output logic r);
        ext_addr_i <= a;
        ext_re_i <= 1'b1;
        @(posedge mclk_i);
        ext_re_i <= 1'b0;
        r = 1'b0;
        repeat (6)
        begin
            @(posedge mclk_i);
            #1;
            if (ext_ready_o === 1'b1 && !r)
            begin
                r = 1'b1;
                v = ext_rdata_o;
            end
        end
        @(posedge mclk_i);
    endtask

    task automatic ext_wr(input logic [7:0] a, input logic [7:0] v);
        ext_addr_i <= a;
        ext_wdata_i <= v;
        ext_we_i <= 1'b1;
        @(posedge mclk_i);
        ext_we_i <= 1'b0;
        repeat (WC + 10) @(posedge mclk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_hold();
        // abort bit has no defined power-up value
        rd(3'h2, d); chk(d & 8'hF7, 8'h00);
        rd(3'h3, d); chk(d, 8'h00);
        rd(3'h7, d); chk(d, 8'h00);
        wr(3'h2, 8'h04);
        seq(8'h55, 8'hAA);
        chk({7'h00, write_busy_o}, 8'h00);
        repeat (HC) @(posedge mclk_i);
        wr(3'h2, 8'h00);
        $display("test hold done");
    endtask

    task automatic t_refuse();
        wr(3'h3, 8'h55);
        wr(3'h3, 8'hAA);
        wr(3'h2, 8'h02);
        rd(3'h2, d); chk(d, 8'h00);
        seq(8'h55, 8'hAA);
        chk({7'h00, write_busy_o}, 8'h00);
        $display("test refuse done");
    endtask

    task automatic t_order();
        wr(3'h2, 8'h04);
        seq(8'hAA, 8'h55);
        chk({7'h00, write_busy_o}, 8'h00);
        wr(3'h3, 8'h55);
        wr(3'h1, 8'h99);
        wr(3'h3, 8'hAA);
        wr(3'h2, 8'h06);
        chk({7'h00, write_busy_o}, 8'h00);
        seq(8'hAA, 8'hAA);
        chk({7'h00, write_busy_o}, 8'h00);
        $display("test order done");
    endtask

    task automatic t_write();
        int n;
        wr(3'h0, 8'h3C);
        wr(3'h1, 8'hA5);
        wr(3'h5, 8'h10);
        seq(8'h55, 8'hAA);
        n = 1;
        #1;
        while (write_busy_o === 1'b1 && n < 100)
        begin
            n++;
            @(posedge mclk_i);
            #1;
        end
        @(posedge mclk_i);
        chk(8'(n), 8'(WC));
        rd(3'h2, d); chk(d, 8'h04);
        rd(3'h4, d); chk(d, 8'h10);
        chk({7'h00, nvm_done_irq_o}, 8'h01);
        wr(3'h5, 8'h00);
        chk({7'h00, nvm_done_irq_o}, 8'h00);
        wr(3'h5, 8'h10);
        wr(3'h4, 8'h00);
        rd(3'h4, d); chk(d, 8'h00);
        $display("test write done");
    endtask

    task automatic t_lock();
        wr(3'h0, 8'h5A);
        wr(3'h1, 8'hC3);
        seq(8'h55, 8'hAA);
        rd(3'h2, d); chk(d, 8'h0E);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h00);
        rd(3'h0, d); chk(d, 8'h5A);
        rd(3'h1, d); chk(d, 8'hC3);
        rd(3'h2, d); chk(d, 8'h0E);
        wait_idle();
        core_rd(8'h3C, d); chk(d, 8'hA5);
        core_rd(8'h5A, d); chk(d, 8'hC3);
        $display("test lock done");
    endtask

    task automatic t_ext();
        code_protect_i <= 1'b1;
        ext_rd(8'h3C, d, ok); chk({7'h00, ok}, 8'h00);
        ext_wr(8'h3C, 8'h11);
        core_rd(8'h3C, d); chk(d, 8'hA5);
        code_protect_i <= 1'b0;
        ext_rd(8'h3C, d, ok); chk({7'h00, ok}, 8'h01);
        chk(d, 8'hA5);
        ext_wr(8'h3C, 8'h11);
        core_rd(8'h3C, d); chk(d, 8'h11);
        $display("test ext done");
    endtask

    // read and rewrite in place, then a new value, all under protection
    task automatic t_refresh();
        code_protect_i <= 1'b1;
        core_rd(8'h3C, d); chk(d, 8'h11);
        seq(8'h55, 8'hAA);
        wait_idle();
        core_rd(8'h3C, d); chk(d, 8'h11);
        wr(3'h1, 8'h3E);
        seq(8'h55, 8'hAA);
        wait_idle();
        core_rd(8'h3C, d); chk(d, 8'h3E);
        wr(3'h2, 8'h00);
        code_protect_i <= 1'b0;
        $display("test refresh done");
    endtask

    // reset in mid-write: busy drops, abort stays set
    task automatic t_reset();
        wr(3'h2, 8'h04);
        seq(8'h55, 8'hAA);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        chk({7'h00, write_busy_o}, 8'h00);
        rd(3'h2, d); chk(d, 8'h08);
        $display("test reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        t_hold();
        t_refuse();
        t_order();
        t_write();
        t_lock();
        t_ext();
        t_refresh();
        t_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
